/* File: design/vsd_pkg.sv */
package vsd_pkg;

  // ------------------------------------------------------------------
  // Address modifier codes.
  // ------------------------------------------------------------------
  localparam logic [5:0] AM_A24_SUP_BLT  = 6'h3F;
  localparam logic [5:0] AM_A24_SUP_DATA = 6'h3D;
  localparam logic [5:0] AM_A24_SUP_MBLT = 6'h3C;
  localparam logic [5:0] AM_A24_USR_BLT  = 6'h3B;
  localparam logic [5:0] AM_A24_USR_DATA = 6'h39;
  localparam logic [5:0] AM_A24_USR_MBLT = 6'h38;
  localparam logic [5:0] AM_CFG_SPACE    = 6'h2F;
  localparam logic [5:0] AM_A32_SUP_BLT  = 6'h0F;
  localparam logic [5:0] AM_A32_SUP_DATA = 6'h0D;
  localparam logic [5:0] AM_A32_SUP_MBLT = 6'h0C;
  localparam logic [5:0] AM_A32_USR_BLT  = 6'h0B;
  localparam logic [5:0] AM_A32_USR_DATA = 6'h09;
  localparam logic [5:0] AM_A32_USR_MBLT = 6'h08;

  // ------------------------------------------------------------------
  // Device register offsets and the output buffer window.
  // ------------------------------------------------------------------
  localparam logic [15:0] OFS_OUTBUF_LAST = 16'h07FC;
  localparam logic [15:0] OFS_FW_REV      = 16'h1000;
  localparam logic [15:0] OFS_GEO         = 16'h1002;
  localparam logic [15:0] OFS_SHARED_ADDR = 16'h1004;
  localparam logic [15:0] OFS_BIT_SET1    = 16'h1006;
  localparam logic [15:0] OFS_BIT_CLR1    = 16'h1008;
  localparam logic [15:0] OFS_BASE_HIGH   = 16'h1012;
  localparam logic [15:0] OFS_BASE_LOW    = 16'h1014;
  localparam logic [15:0] OFS_CHAIN_CTRL  = 16'h101A;

  // Field positions and reset values.
  localparam int          BIT_USE_PROG_BASE = 4;
  localparam int          BIT_FIRST_BOARD   = 1;
  localparam int          BIT_LAST_BOARD    = 0;
  localparam logic [7:0]  RST_SHARED_ADDR   = 8'hAA;
  localparam logic [7:0]  RST_BIT_SET1      = 8'h00;
  localparam logic [1:0]  RST_CHAIN_CTRL    = 2'h0;
  localparam logic [7:0]  RST_BASE_BYTE     = 8'h00;
  localparam logic [4:0]  RST_GEO           = 5'h00;

  // Data word type field: header and end-of-block words.
  localparam int          WORD_TYPE_MSB     = 26;
  localparam int          WORD_TYPE_LSB     = 24;
  localparam logic [2:0]  WORD_TYPE_HEADER  = 3'h2;
  localparam logic [2:0]  WORD_TYPE_EOB     = 3'h4;

  // ------------------------------------------------------------------
  // Host command registers on APB.
  // ------------------------------------------------------------------
  localparam logic [7:0]  APB_CMD_ADDR = 8'h00;
  localparam logic [7:0]  APB_CMD_DATA = 8'h04;
  localparam logic [7:0]  APB_CMD_CTRL = 8'h08;
  localparam logic [7:0]  APB_STATUS   = 8'h0C;
  localparam logic [7:0]  APB_RDATA    = 8'h10;
  localparam int          CTRL_WRITE_BIT = 6;
  localparam int          CTRL_GO_BIT    = 8;
  localparam int          HOST_TIMEOUT_CYCLES = 1000;

endpackage : vsd_pkg

/* File: design/vsd_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Link between the bus master and one board.
interface vsd_bus_if;
  logic        strobe;
  logic        writeEn;
  logic [5:0]  am;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        dtack;
  logic        berr;

  modport master (output strobe, writeEn, am, addr, wdata,
                  input  rdata, dtack, berr);
  modport board  (input  strobe, writeEn, am, addr, wdata,
                  output rdata, dtack, berr);
endinterface : vsd_bus_if

`default_nettype wire

/* File: design/vsd_board.sv */
`timescale 1ns/1ps
`default_nettype none

module vsd_board
  import vsd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  vsd_bus_if.board         bus,
  input  wire logic [4:0]  slotIdLines,
  input  wire logic        auxBackplaneConnector,
  input  wire logic [15:0] baseSwitches,
  input  wire logic        iackIn,
  output logic             iackOut,
  input  wire logic [31:0] bufData,
  input  wire logic        bufEmpty,
  output logic             bufRead
);
  import vsd_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } vsd_state_t;

  // ------------------------------------------------------------------
  // Pin synchronisers.
  // ------------------------------------------------------------------
  logic [21:0] pinMeta_q;
  logic [21:0] pinSync_q;

  // Two flip-flops on the strap, slot and switch pins, not on iackIn.
  always_ff @(posedge core_clk) begin
    pinMeta_q <= {auxBackplaneConnector, slotIdLines, baseSwitches};
    pinSync_q <= pinMeta_q;
  end

  logic        hasAux;
  logic [4:0]  slotSync;
  logic [15:0] switchSync;
  assign {hasAux, slotSync, switchSync} = pinSync_q;

  // ------------------------------------------------------------------
  // Modifier classes.
  // ------------------------------------------------------------------
  function automatic logic amIsA24Base(input logic [5:0] m);
    return m == AM_A24_SUP_BLT  || m == AM_A24_SUP_DATA ||
           m == AM_A24_SUP_MBLT || m == AM_A24_USR_BLT  ||
           m == AM_A24_USR_DATA || m == AM_A24_USR_MBLT;
  endfunction : amIsA24Base

  function automatic logic amIsA32Base(input logic [5:0] m);
    return m == AM_A32_SUP_BLT  || m == AM_A32_SUP_DATA ||
           m == AM_A32_SUP_MBLT || m == AM_A32_USR_BLT  ||
           m == AM_A32_USR_DATA || m == AM_A32_USR_MBLT;
  endfunction : amIsA32Base

  // ------------------------------------------------------------------
  // State and registers.
  // ------------------------------------------------------------------
  vsd_state_t  state_q, state_d;
  logic [4:0]  geo_q, geo_d;
  logic        geoArm_q, geoArm_d;
  logic [7:0]  sharedAddr_q, sharedAddr_d;
  logic [7:0]  bitSet_q, bitSet_d;
  logic [7:0]  baseHigh_q, baseHigh_d;
  logic [7:0]  baseLow_q, baseLow_d;
  logic [1:0]  chainCtrl_q, chainCtrl_d;
  logic        iackOut_q, iackOut_d;
  logic        mcstPass_q, mcstPass_d;
  logic        dtack_q, dtack_d;
  logic        berr_q, berr_d;
  logic [31:0] rdata_q, rdata_d;
  logic        bufRead_q, bufRead_d;

  // Address decode terms.
  logic [15:0] baseAddr;
  logic [15:0] ofs;
  logic        isOutBuf;
  logic        hitBase;
  logic        hitGeo;
  logic        hitChain;
  logic        firstBoard;
  logic        lastBoard;
  logic        tokenHeld;
  logic        chainRead;
  logic        chainWrite;
  logic        regWrite;
  logic [15:0] regRdata;

  always_comb begin
    // Base comes from switches unless bit 4 selects the registers.
    baseAddr = bitSet_q[BIT_USE_PROG_BASE] ?
               {baseHigh_q, baseLow_q} : switchSync;
    ofs        = bus.addr[15:0];
    isOutBuf   = ofs <= OFS_OUTBUF_LAST;
    firstBoard = chainCtrl_q[BIT_FIRST_BOARD];
    lastBoard  = chainCtrl_q[BIT_LAST_BOARD];
    // Base decode with A24 or A32 modifiers.
    hitBase = 1'b0;
    if (amIsA24Base(bus.am)) begin
      hitBase = bus.addr[23:16] == baseAddr[7:0];
    end else if (amIsA32Base(bus.am)) begin
      hitBase = bus.addr[31:16] == baseAddr;
    end
    // Geographical decode; needs the slot connector and no buffer.
    hitGeo = bus.am == AM_CFG_SPACE && hasAux &&
             bus.addr[23:19] == geo_q && bus.addr[18:16] == 3'h0 &&
             !isOutBuf;
    // Shared address decode for the chain modes.
    hitChain = bus.addr[31:24] == sharedAddr_q &&
               bus.addr[23:16] == 8'h00 &&
               (firstBoard || lastBoard);
    // The token sits on the first board, else arrives on iackIn.
    tokenHeld = firstBoard ? !iackOut_q : (iackIn && !iackOut_q);
    chainRead = hitChain && !bus.writeEn && isOutBuf &&
                (bus.am == AM_A32_SUP_BLT ||
                 bus.am == AM_A32_USR_BLT);
    chainWrite = hitChain && bus.writeEn && !isOutBuf &&
                 (bus.am == AM_A32_SUP_DATA ||
                  bus.am == AM_A32_USR_DATA);
  end

  // Register read multiplexer.
  always_comb begin
    regRdata = 16'h0000;
    if (ofs == OFS_GEO) begin
      regRdata = {11'h0, geo_q};
    end else if (ofs == OFS_SHARED_ADDR) begin
      regRdata = {8'h00, sharedAddr_q};
    end else if (ofs == OFS_BIT_SET1 || ofs == OFS_BIT_CLR1) begin
      regRdata = {8'h00, bitSet_q};
    end else if (ofs == OFS_BASE_HIGH) begin
      regRdata = {8'h00, baseHigh_q};
    end else if (ofs == OFS_BASE_LOW) begin
      regRdata = {8'h00, baseLow_q};
    end else if (ofs == OFS_CHAIN_CTRL) begin
      regRdata = {14'h0, chainCtrl_q};
    end
  end

  // ------------------------------------------------------------------
  // Cycle handling: decode, act once, hold the answer.
  // ------------------------------------------------------------------
  always_comb begin
    state_d      = state_q;
    geo_d        = geo_q;
    geoArm_d     = 1'b0;
    sharedAddr_d = sharedAddr_q;
    bitSet_d     = bitSet_q;
    baseHigh_d   = baseHigh_q;
    baseLow_d    = baseLow_q;
    chainCtrl_d  = chainCtrl_q;
    iackOut_d    = iackOut_q;
    mcstPass_d   = mcstPass_q;
    dtack_d      = dtack_q;
    berr_d       = berr_q;
    rdata_d      = rdata_q;
    bufRead_d    = 1'b0;
    regWrite     = 1'b0;
    // With the slot connector present, slot lines are taken on the first edge after reset release.
    if (geoArm_q && hasAux) begin
      geo_d = slotSync;
    end
    case (state_q)
      ST_IDLE: begin
        if (bus.strobe) begin
          if (hitBase || hitGeo) begin
            // Ordinary access ends any chain transfer in progress.
            iackOut_d = 1'b0;
            state_d   = ST_HOLD;
            dtack_d   = 1'b1;
            if (bus.writeEn) begin
              regWrite = !isOutBuf;
            end else if (isOutBuf) begin
              rdata_d   = bufData;
              bufRead_d = !bufEmpty;
            end else begin
              rdata_d = {16'h0000, regRdata};
            end
          end else if (chainWrite && tokenHeld) begin
            // Each board takes the command, then hands the token on.
            regWrite   = 1'b1;
            iackOut_d  = 1'b1;
            mcstPass_d = 1'b1;
            state_d    = ST_HOLD;
            dtack_d    = lastBoard && !firstBoard;
          end else if (chainRead && tokenHeld) begin
            if (!bufEmpty) begin
              rdata_d = bufData;
              if (bufData[WORD_TYPE_MSB:WORD_TYPE_LSB] == WORD_TYPE_HEADER ||
                  bufData[WORD_TYPE_MSB:WORD_TYPE_LSB] == WORD_TYPE_EOB) begin
                rdata_d[31:27] = geo_q;
              end
              bufRead_d = 1'b1;
              dtack_d   = 1'b1;
              state_d   = ST_HOLD;
            end else if (lastBoard && !firstBoard) begin
              // The last board ends the chained transfer.
              berr_d  = 1'b1;
              state_d = ST_HOLD;
            end else begin
              iackOut_d = 1'b1;
            end
          end
          // Anything else is ignored and left unanswered.
        end
      end
      ST_HOLD: begin
        if (!bus.strobe) begin
          dtack_d = 1'b0;
          berr_d  = 1'b0;
          state_d = ST_IDLE;
          if (mcstPass_q) begin
            mcstPass_d = 1'b0;
            iackOut_d  = 1'b0;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Register writes from any decoded path.
    if (regWrite) begin
      if (ofs == OFS_GEO && !hasAux) begin
        geo_d = bus.wdata[4:0];
      end else if (ofs == OFS_SHARED_ADDR) begin
        sharedAddr_d = bus.wdata[7:0];
      end else if (ofs == OFS_BIT_SET1) begin
        bitSet_d = bitSet_q | bus.wdata[7:0];
      end else if (ofs == OFS_BIT_CLR1) begin
        bitSet_d = bitSet_q & ~bus.wdata[7:0];
      end else if (ofs == OFS_BASE_HIGH) begin
        baseHigh_d = bus.wdata[7:0];
      end else if (ofs == OFS_BASE_LOW) begin
        baseLow_d = bus.wdata[7:0];
      end else if (ofs == OFS_CHAIN_CTRL) begin
        chainCtrl_d = bus.wdata[1:0];
      end
    end
  end

  // State registers with synchronous reset.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q      <= ST_IDLE;
      geo_q        <= RST_GEO;
      geoArm_q     <= 1'b1;
      sharedAddr_q <= RST_SHARED_ADDR;
      bitSet_q     <= RST_BIT_SET1;
      baseHigh_q   <= RST_BASE_BYTE;
      baseLow_q    <= RST_BASE_BYTE;
      chainCtrl_q  <= RST_CHAIN_CTRL;
      iackOut_q    <= 1'b0;
      mcstPass_q   <= 1'b0;
      dtack_q      <= 1'b0;
      berr_q       <= 1'b0;
      rdata_q      <= 32'h0000_0000;
      bufRead_q    <= 1'b0;
    end else begin
      state_q      <= state_d;
      geo_q        <= geo_d;
      geoArm_q     <= geoArm_d;
      sharedAddr_q <= sharedAddr_d;
      bitSet_q     <= bitSet_d;
      baseHigh_q   <= baseHigh_d;
      baseLow_q    <= baseLow_d;
      chainCtrl_q  <= chainCtrl_d;
      iackOut_q    <= iackOut_d;
      mcstPass_q   <= mcstPass_d;
      dtack_q      <= dtack_d;
      berr_q       <= berr_d;
      rdata_q      <= rdata_d;
      bufRead_q    <= bufRead_d;
    end
  end

  assign bus.dtack = dtack_q;
  assign bus.berr  = berr_q;
  assign bus.rdata = rdata_q;
  assign iackOut   = iackOut_q;
  assign bufRead   = bufRead_q;

endmodule : vsd_board

`default_nettype wire

/* File: design/vsd_master.sv */
`timescale 1ns/1ps
`default_nettype none

// Bus master driven by software over APB.
module vsd_master
  import vsd_pkg::*;
#(
  parameter int TIMEOUT = HOST_TIMEOUT_CYCLES
)(
  input  wire logic        core_clk,
  input  wire logic        reset,
  vsd_bus_if.master        bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  import vsd_pkg::*;

  typedef enum logic [2:0] {
    MS_IDLE  = 3'b001,
    MS_WAIT  = 3'b010,
    MS_CLOSE = 3'b100
  } vsd_mstate_t;

  // ------------------------------------------------------------------
  // Command registers and cycle engine.
  // ------------------------------------------------------------------
  vsd_mstate_t mstate_q, mstate_d;
  logic [31:0] cmdAddr_q, cmdAddr_d;
  logic [31:0] cmdData_q, cmdData_d;
  logic [5:0]  cmdAm_q, cmdAm_d;
  logic        cmdWr_q, cmdWr_d;
  logic [31:0] rdBack_q, rdBack_d;
  logic [3:0]  status_q, status_d;
  logic [15:0] timer_q, timer_d;
  logic        strobe_q, strobe_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pslverr_q, pslverr_d;
  logic        pready_q, pready_d;
  logic        apbWr;
  logic        apbRd;

  always_comb begin
    mstate_d  = mstate_q;
    cmdAddr_d = cmdAddr_q;
    cmdData_d = cmdData_q;
    cmdAm_d   = cmdAm_q;
    cmdWr_d   = cmdWr_q;
    rdBack_d  = rdBack_q;
    status_d  = status_q;
    timer_d   = timer_q;
    strobe_d  = strobe_q;
    prdata_d  = 32'h0000_0000;
    pslverr_d = 1'b0;
    // Ready stands for exactly the access phase after each setup.
    pready_d  = psel && !penable;
    // Reads and refusals are decoded in setup; writes land on access.
    apbWr = psel && penable && pwrite;
    apbRd = psel && !penable && !pwrite;
    if (psel && !penable && pwrite && paddr != APB_CMD_ADDR &&
        paddr != APB_CMD_DATA && paddr != APB_CMD_CTRL &&
        paddr != APB_STATUS && paddr != APB_RDATA) begin
      pslverr_d = 1'b1;
    end
    if (apbRd) begin
      if (paddr == APB_CMD_ADDR) begin
        prdata_d = cmdAddr_q;
      end else if (paddr == APB_CMD_DATA) begin
        prdata_d = cmdData_q;
      end else if (paddr == APB_CMD_CTRL) begin
        prdata_d = {25'h0, cmdWr_q, cmdAm_q};
      end else if (paddr == APB_STATUS) begin
        prdata_d = {28'h0, status_q};
      end else if (paddr == APB_RDATA) begin
        prdata_d = rdBack_q;
      end else begin
        pslverr_d = 1'b1;
      end
    end
    if (apbWr) begin
      if (paddr == APB_CMD_ADDR) begin
        cmdAddr_d = pwdata;
      end else if (paddr == APB_CMD_DATA) begin
        cmdData_d = pwdata;
      end else if (paddr == APB_CMD_CTRL) begin
        cmdAm_d = pwdata[5:0];
        cmdWr_d = pwdata[CTRL_WRITE_BIT];
        if (pwdata[CTRL_GO_BIT] && mstate_q == MS_IDLE) begin
          mstate_d = MS_WAIT;
          strobe_d = 1'b1;
          timer_d  = 16'h0000;
          status_d = 4'h1;
        end
      end
    end
    case (mstate_q)
      MS_IDLE: begin
      end
      MS_WAIT: begin
        // Wait for acknowledge, bus error or the timeout.
        timer_d = timer_q + 16'h0001;
        if (bus.dtack) begin
          rdBack_d = bus.rdata;
          status_d = 4'h2;
          strobe_d = 1'b0;
          mstate_d = MS_CLOSE;
        end else if (bus.berr) begin
          status_d = 4'h6;
          strobe_d = 1'b0;
          mstate_d = MS_CLOSE;
        end else if (timer_q == 16'(TIMEOUT - 1)) begin
          status_d = 4'hA;
          strobe_d = 1'b0;
          mstate_d = MS_CLOSE;
        end
      end
      MS_CLOSE: begin
        if (!bus.dtack && !bus.berr) begin
          mstate_d = MS_IDLE;
        end
      end
      default: begin
        mstate_d = MS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mstate_q  <= MS_IDLE;
      cmdAddr_q <= 32'h0000_0000;
      cmdData_q <= 32'h0000_0000;
      cmdAm_q   <= 6'h00;
      cmdWr_q   <= 1'b0;
      rdBack_q  <= 32'h0000_0000;
      status_q  <= 4'h0;
      timer_q   <= 16'h0000;
      strobe_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      pready_q  <= 1'b0;
    end else begin
      mstate_q  <= mstate_d;
      cmdAddr_q <= cmdAddr_d;
      cmdData_q <= cmdData_d;
      cmdAm_q   <= cmdAm_d;
      cmdWr_q   <= cmdWr_d;
      rdBack_q  <= rdBack_d;
      status_q  <= status_d;
      timer_q   <= timer_d;
      strobe_q  <= strobe_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
      pready_q  <= pready_d;
    end
  end

  assign bus.strobe  = strobe_q;
  assign bus.writeEn = cmdWr_q;
  assign bus.am      = cmdAm_q;
  assign bus.addr    = cmdAddr_q;
  assign bus.wdata   = cmdData_q;
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;

endmodule : vsd_master

`default_nettype wire

/* File: bench/vsd_bus_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Link checks between the master and the board.
// ------------------------------------------------------------
module vsd_bus_asserts (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        strobe,
  input wire logic        writeEn,
  input wire logic [5:0]  am,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        dtack,
  input wire logic        berr
);
  // Every check runs on the core clock and rests during reset.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  property p_ackReq;
    (dtack || berr) |-> $past(strobe);
  endproperty
  a_ackReq: assert property (p_ackReq)
    else $error("answer without request");
  property p_badAm;
    strobe && !(am inside {6'h3F, 6'h3D, 6'h3C, 6'h3B, 6'h39, 6'h38,
      6'h2F, 6'h0F, 6'h0D, 6'h0C, 6'h0B, 6'h09, 6'h08}) |=> !dtack;
  endproperty
  a_badAm: assert property (p_badAm)
    else $error("unknown modifier acknowledged");
  property p_ackShape;
    $rose(dtack) |-> strobe ##1 (dtack && !strobe) ##1 !dtack;
  endproperty
  a_ackShape: assert property (p_ackShape)
    else $error("acknowledge timing wrong");
  property p_berrShape;
    $rose(berr) |-> strobe ##1 berr ##1 !berr;
  endproperty
  a_berrShape: assert property (p_berrShape)
    else $error("end of chain timing wrong");
  property p_rdHold;
    dtack && $past(dtack) |-> $stable(rdata);
  endproperty
  a_rdHold: assert property (p_rdHold)
    else $error("read data moved");
  property p_noBoth;
    !(dtack && berr);
  endproperty
  a_noBoth: assert property (p_noBoth)
    else $error("acknowledge with chain end");
  property p_berrChain;
    $rose(berr) |-> $past(am) inside {6'h0F, 6'h0B} && !$past(writeEn);
  endproperty
  a_berrChain: assert property (p_berrChain)
    else $error("chain end outside chained read");
  property p_order;
    $rose(strobe) |-> !dtack && !berr;
  endproperty
  a_order: assert property (p_order)
    else $error("request while answer stands");
  property p_reqHold;
    strobe && $past(strobe) |-> $stable(addr) && $stable(am)
      && $stable(wdata) && $stable(writeEn);
  endproperty
  a_reqHold: assert property (p_reqHold)
    else $error("request moved");
  c_wr: cover property (dtack && writeEn);
  c_rd: cover property (dtack && !writeEn);
  c_berr: cover property (berr);
endmodule : vsd_bus_asserts
`default_nettype wire

/* File: bench/vme_slave_address_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Software drives the master over APB against one board.
// ------------------------------------------------------------
module vme_slave_address_decoder_tb;
  import vsd_pkg::*;
  localparam logic [3:0] OK = 4'h2;
  localparam logic [3:0] BE = 4'h6;
  localparam logic [3:0] TO = 4'hA;
  logic        core_clk = 1'h0;
  logic        reset = 1'h1;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, bufData;
  logic        pready, pslverr, iackOut, bufRead, bufEmpty;
  logic [4:0]  slotIdLines = 5'h05;
  logic        auxBackplaneConnector = 1'h1, iackIn = 1'h1;
  logic [15:0] baseSwitches = 16'hEE12;
  logic [31:0] bufMem [4] = '{default: 32'h0};
  int          bufPops = 0, bufStart = 0, bufLen = 0, fails = 0, checked = 0;
  int          bufIdx;
  logic        lastErr = 1'h0;
  logic [5:0]  amOk [12] = '{6'h3F, 6'h3D, 6'h3C, 6'h3B, 6'h39, 6'h38,
                             6'h0F, 6'h0D, 6'h0C, 6'h0B, 6'h09, 6'h08};
  logic [5:0]  amBad [4] = '{6'h3E, 6'h2E, 6'h0E, 6'h0A};
  vsd_bus_if bus ();
  vsd_master #(.TIMEOUT(20)) vsd_master_i (.core_clk, .reset, .bus,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  vsd_board vsd_board_i (.core_clk, .reset, .bus, .slotIdLines,
    .auxBackplaneConnector, .baseSwitches, .iackIn, .iackOut, .bufData,
    .bufEmpty, .bufRead);
  vsd_bus_asserts vsd_bus_asserts_i (.core_clk, .reset,
    .strobe(bus.strobe), .writeEn(bus.writeEn), .am(bus.am),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
    .dtack(bus.dtack), .berr(bus.berr));
  // Clock and the output buffer model, popped on each consumed word.
  always #10 core_clk = ~core_clk;
  assign bufIdx = bufPops - bufStart;
  assign bufData = bufMem[bufIdx[1:0]];
  assign bufEmpty = (bufIdx >= bufLen);
  always @(posedge core_clk) if (bufRead === 1'h1) bufPops <= bufPops + 1;
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; the request holds until pready is sampled.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    for (int n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (pready === 1'h1) break;
    end
    if (pready !== 1'h1) begin
      $display("FAIL %0t no pready", $time);
      fails++;
      end_sim();
    end
    q = prdata;
    lastErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask : apb
  // Runs one link cycle through the master and checks its status.
  task automatic go(input logic [5:0] m, input logic [31:0] a,
                    input logic w, input logic [31:0] d, input logic [3:0] st);
    logic [31:0] q;
    apb(1'h1, APB_CMD_ADDR, a, q);
    apb(1'h1, APB_CMD_DATA, d, q);
    apb(1'h1, APB_CMD_CTRL, {23'h0, 1'h1, 1'h0, w, m}, q);
    q = 32'h1;
    for (int n = 0; n < 100 && q[3:0] === 4'h1; n++)
      apb(1'h0, APB_STATUS, 32'h0, q);
    if (q[3:0] === 4'h1) begin
      $display("FAIL %0t stuck busy", $time);
      fails++;
      end_sim();
    end
    chk({28'h0, q[3:0]}, {28'h0, st});
  endtask : go
  // Read cycle; data is compared only when the cycle is expected to be acknowledged.
  task automatic rd(input logic [5:0] m, input logic [31:0] a,
                    input logic [3:0] st, input logic [31:0] ex);
    logic [31:0] q;
    go(m, a, 1'h0, 32'h0, st);
    apb(1'h0, APB_RDATA, 32'h0, q);
    if (st === OK) chk(q, ex);
  endtask : rd
  // Holds reset for four cycles with the chosen slot strap.
  task automatic rst(input logic ax);
    reset <= 1'h1;
    auxBackplaneConnector <= ax;
    repeat (4) @(posedge core_clk);
    reset <= 1'h0;
    repeat (4) @(posedge core_clk);
  endtask : rst
  // Modifier table through the switch base, then refused cycles.
  task automatic s_base();
    logic [31:0] q;
    for (int i = 0; i < 12; i++)
      rd(amOk[i], 32'hEE121004, OK, 32'hAA);
    for (int i = 0; i < 4; i++)
      rd(amBad[i], 32'hEE121004, TO, 32'h0);
    rd(6'h3D, 32'h00131004, TO, 32'h0);
    rd(6'h0D, 32'hEF121004, TO, 32'h0);
    rd(6'h0D, 32'hEE12101A, OK, 32'h0);
    chk({31'h0, lastErr}, 32'h0);
    apb(1'h0, 8'h14, 32'h0, q);
    chk({31'h0, lastErr}, 32'h1);
    apb(1'h1, 8'h18, 32'h0, q);
    chk({31'h0, lastErr}, 32'h1);
  endtask : s_base
  // Slot addressing with the strap present.
  task automatic s_geo();
    rd(6'h2F, 32'h77281004, OK, 32'hAA);
    rd(6'h2F, 32'h00291004, TO, 32'h0);
    rd(6'h2F, 32'h00301004, TO, 32'h0);
    rd(6'h2F, 32'h00280000, TO, 32'h0);
    rd(6'h3D, 32'h00281004, TO, 32'h0);
  endtask : s_geo
  // Programmable base takes over from the switches and back.
  task automatic s_prog();
    go(6'h0D, 32'hEE121012, 1'h1, 32'h55, OK);
    go(6'h0D, 32'hEE121014, 1'h1, 32'h66, OK);
    go(6'h0D, 32'hEE121006, 1'h1, 32'h10, OK);
    rd(6'h0D, 32'h55661006, OK, 32'h10);
    rd(6'h3D, 32'h00661004, OK, 32'hAA);
    rd(6'h0D, 32'hEE121004, TO, 32'h0);
    go(6'h0D, 32'h55661008, 1'h1, 32'h10, OK);
    rd(6'h0D, 32'hEE121006, OK, 32'h0);
  endtask : s_prog
  // Multicast writes, chained reads and the token.
  task automatic s_chain();
    go(6'h0D, 32'hEE12101A, 1'h1, 32'h1, OK);
    go(6'h0D, 32'hAA001014, 1'h1, 32'h77, OK);
    rd(6'h0D, 32'hEE121014, OK, 32'h77);
    go(6'h09, 32'hEE121004, 1'h1, 32'hBB, OK);
    go(6'h09, 32'hAA001014, 1'h1, 32'h11, TO);
    go(6'h09, 32'hBB011014, 1'h1, 32'h11, TO);
    rd(6'h0D, 32'hBB001004, TO, 32'h0);
    bufMem <= '{32'hFA000123, 32'hFC0000AB, 32'h0, 32'h0};
    bufStart <= bufPops;
    bufLen <= 2;
    rd(6'h0F, 32'hBB001004, TO, 32'h0);
    rd(6'h0F, 32'hBB000000, OK, 32'h2A000123);
    rd(6'h0B, 32'hBB000000, OK, 32'h2C0000AB);
    rd(6'h0F, 32'hBB000000, BE, 32'h0);
    bufStart <= bufPops;
    iackIn <= 1'h0;
    rd(6'h0F, 32'hBB000000, TO, 32'h0);
    chk(bufIdx, 32'h0);
    iackIn <= 1'h1;
    bufLen <= 0;
    go(6'h0D, 32'hEE12101A, 1'h1, 32'h2, OK);
    rd(6'h0F, 32'hBB000000, TO, 32'h0);
    chk({31'h0, iackOut}, 32'h1);
    rd(6'h0D, 32'hEE12101A, OK, 32'h2);
    chk({31'h0, iackOut}, 32'h0);
    go(6'h0D, 32'hEE12101A, 1'h1, 32'h0, OK);
    go(6'h0D, 32'hBB001014, 1'h1, 32'h1, TO);
  endtask : s_chain
  // Without slot lines the slot register only tags data.
  task automatic s_noAux();
    rst(1'h0);
    rd(6'h2F, 32'h00281004, TO, 32'h0);
    go(6'h0D, 32'hEE121002, 1'h1, 32'h09, OK);
    rd(6'h0D, 32'hEE121002, OK, 32'h09);
    rd(6'h2F, 32'h00481004, TO, 32'h0);
    go(6'h0D, 32'hEE12101A, 1'h1, 32'h1, OK);
    bufMem <= '{32'hFA000123, 32'h0, 32'h0, 32'h0};
    bufStart <= bufPops;
    bufLen <= 1;
    rd(6'h0F, 32'hAA000000, OK, 32'h4A000123);
  endtask : s_noAux
  // Main sequence.
  initial begin
    rst(1'h1);
    s_base();
    s_geo();
    s_prog();
    s_chain();
    s_noAux();
    end_sim();
  end
endmodule : vme_slave_address_decoder_tb
`default_nettype wire
